//--- dv/splk_protect_lock_asserts.sv
/* checker for the sector protection lock block, watching its pins only.
   assumes clkEn held high and serial clock phases of at least 4 sys_clk. */
`timescale 1ns/1ps
module splk_protect_lock_asserts (
    // clocking
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // serial pins
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic writeProtN,
    // status
    input wire logic protectionLockBit,
    input wire logic [1:0] protectionSummaryField,
    input wire logic hwLocked,
    input wire logic [splk_pkg::NumSectors-1:0] sectorProtBits
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // state and output checks; pin is seen two cycles late through the synchroniser
    reset_state_a: assert property ($rose(rst_n) |-> sectorProtBits == splk_pkg::ProtResetAll && !protectionLockBit)
        else $error("sectors not all protected after reset");
    hw_lock_def_a: assert property (rst_n && $past(rst_n) && $past(rst_n, 2) |-> hwLocked == (protectionLockBit && !$past(writeProtN, 2)))
        else $error("hardware lock flag wrong");
    summary_value_a: assert property (protectionSummaryField == (&sectorProtBits ? splk_pkg::SumAll : (|sectorProtBits ? splk_pkg::SumSome : splk_pkg::SumNone)))
        else $error("summary field wrong");
    hw_frozen_a: assert property (hwLocked |=> protectionLockBit && $stable(sectorProtBits))
        else $error("state changed under hardware lock");
    lock_freeze_a: assert property (protectionLockBit |=> $stable(sectorProtBits))
        else $error("sector bits changed while locked");
    lock_clear_a: assert property ($past(rst_n) && $fell(protectionLockBit) |-> $past(!hwLocked))
        else $error("lock cleared under hardware lock");
    oe_release_a: assert property (chipSelN [*3] |-> !serialOutEn)
        else $error("output driven after select release");
    oe_stands_a: assert property ($past(rst_n) && $fell(serialOutEn) |-> $past(chipSelN, 2))
        else $error("output enable dropped inside frame");
    out_shift_a: assert property (serialOutEn && $past(serialOutEn) && $changed(serialOut) |-> !serialClk)
        else $error("output bit changed in clock high phase");
    // main scenarios reached
    cover property (hwLocked);
    cover property (serialOutEn && !serialOut);
    cover property (protectionSummaryField == splk_pkg::SumSome);
endmodule : splk_protect_lock_asserts

//--- dv/splk_protect_lock_bench.sv
/* self-checking bench for the protection lock block with an integer model.
   assumes the spi host model and checker files are compiled first. */
`timescale 1ns/1ps
module splk_protect_lock_bench;
    logic sys_clk, rst_n, writeProtN, chipSelN, serialClk, serialIn, serialOut, serialOutEn, lockBit, hwLocked;
    logic [1:0] summary;
    logic [3:0] protBits;
    logic [31:0] seed;
    logic [15:0] rd;
    int fails, checksDone, cycles, protM, lockM, i;

    splk_protect_lock i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(1'b1), .chipSelN(chipSelN),
        .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .writeProtN(writeProtN), .protectionLockBit(lockBit), .protectionSummaryField(summary),
        .hwLocked(hwLocked), .sectorProtBits(protBits));
    splk_spi_host i_host (.sys_clk(sys_clk), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    // compare every status output with the model
    task automatic state_chk();
        chk("prot", {12'h000, protBits}, 16'(protM));
        chk("lock", {15'h0000, lockBit}, 16'(lockM));
        chk("summary", {14'h0000, summary}, protM == 15 ? 16'h0003 : (protM == 0 ? 16'h0000 : 16'h0001));
        chk("hwlock", {15'h0000, hwLocked}, 16'(lockM == 1 && writeProtN == 1'b0));
    endtask : state_chk
    task automatic setwp(input logic v);
        writeProtN = v;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : setwp
    // one command frame, then the model takes the same command
    task automatic cmd(input logic [7:0] op, input logic [23:0] arg);
        int hw, g;
        hw = lockM == 1 && writeProtN == 1'b0;
        g = int'(arg[5:2]);
        if (op == splk_pkg::OpWriteStatus) i_host.frame({op, arg[7:0], 16'h0000}, 16, 0, rd);
        else i_host.frame({op, arg}, 32, 0, rd);
        if (op != splk_pkg::OpWriteStatus) begin
            // sector commands only act while unlocked
            if (lockM == 0) protM = op == splk_pkg::OpProtect ? protM | (1 << arg[17:16]) : protM & ~(1 << arg[17:16]);
        end else if (hw == 0) begin
            if (lockM == 0 && g == 15) protM = 15;
            if (lockM == 0 && g == 0) protM = 0;
            lockM = int'(arg[7]);
        end
        state_chk();
    endtask : cmd
    // read one sector's byte from a random address inside it
    task automatic rd_chk(input int s, input int nr);
        logic [31:0] r;
        r = rnd();
        i_host.frame({splk_pkg::OpReadProt, 6'h00, 2'(s), r[15:0]}, 32, nr, rd);
        chk("rdata", rd, ((protM >> s) & 1) == 1 ? 16'((1 << nr) - 1) : 16'h0000);
        chk("oe", {15'h0000, serialOutEn}, 16'h0000);
    endtask : rd_chk

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // hang guard, well above the expected run length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        seed = 32'he00d;
        rst_n = 1'b0;
        writeProtN = 1'b1;
        protM = 15;
        lockM = 0;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        setwp(1'b1);
        state_chk();
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            setwp(1'(rnd()));
            rd_chk(i, 16);
        end
        $display("test read done");
        cmd(splk_pkg::OpUnprotect, {6'h00, 2'h1, 16'(rnd())});
        rd_chk(1, 16);
        rd_chk(0, 5);
        cmd(splk_pkg::OpWriteStatus, 24'h000000);
        cmd(splk_pkg::OpProtect, {6'h00, 2'h2, 16'(rnd())});
        cmd(splk_pkg::OpWriteStatus, 24'h00007f);
        $display("test global done");
        setwp(1'b1);
        cmd(splk_pkg::OpWriteStatus, 24'h0000f0);
        cmd(splk_pkg::OpUnprotect, 24'h030000);
        cmd(splk_pkg::OpWriteStatus, 24'h000000);
        $display("test soft lock done");
        cmd(splk_pkg::OpWriteStatus, 24'h000080);
        setwp(1'b0);
        state_chk();
        cmd(splk_pkg::OpWriteStatus, 24'h00007c);
        cmd(splk_pkg::OpProtect, 24'h000000);
        rd_chk(0, 3);
        $display("test hard lock done");
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        protM = 15;
        lockM = 0;
        setwp(1'b0);
        state_chk();
        $display("test second reset done");
        wrap_up();
    end
endmodule : splk_protect_lock_bench

bind splk_protect_lock splk_protect_lock_asserts i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .writeProtN(writeProtN), .protectionLockBit(protectionLockBit),
    .protectionSummaryField(protectionSummaryField), .hwLocked(hwLocked), .sectorProtBits(sectorProtBits));

//--- dv/splk_spi_host.sv
/* spi host model, mode 0, for the protection lock block.
   assumes one caller at a time; each clock phase lasts 5 sys_clk. */
`timescale 1ns/1ps
module splk_spi_host (
    // clocking
    input wire logic sys_clk,
    // from device
    input wire logic serialOut,
    input wire logic serialOutEn,
    // to device
    output logic chipSelN,
    output logic serialClk,
    output logic serialIn
);
    // clock idles low between frames
    initial begin
        chipSelN = 1'b1;
        serialClk = 1'b0;
        serialIn = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    // nb bits out msb first, then nr bits in; select may rise mid byte
    task automatic frame(input logic [31:0] w, input int nb, input int nr, output logic [15:0] rd);
        int i;
        rd = 16'h0000;
        cyc(1);
        chipSelN = 1'b0;
        cyc(5);
        for (i = 0; i < nb + nr; i++) begin
            serialClk = 1'b0;
            if (i < nb) serialIn = w[31 - i];
            cyc(5);
            // a released line reads inverted, so a missing enable shows as bad data
            if (i >= nb) rd = {rd[14:0], serialOutEn ? serialOut : ~serialOut};
            serialClk = 1'b1;
            cyc(5);
        end
        serialClk = 1'b0;
        cyc(5);
        chipSelN = 1'b1;
        serialIn = ~serialIn;
        cyc(5);
    endtask : frame
endmodule : splk_spi_host

//--- hw/splk_cmd_if.sv
/*
 * interface carrying decoded commands from the frame engine to the
 * protection store, and the store state back.
 * assumes both ends share sys_clk.
 */
`timescale 1ns/1ps
interface splk_cmd_if;
    logic protStrobe;
    logic unprotStrobe;
    logic wrStatStrobe;
    logic [splk_pkg::SectorIdxW-1:0] sector;
    logic [7:0] statData;
    logic [splk_pkg::NumSectors-1:0] protBits;
    logic lockBit;
    modport engine (output protStrobe, output unprotStrobe, output wrStatStrobe, output sector,
                    output statData, input protBits, input lockBit);
    modport store (input protStrobe, input unprotStrobe, input wrStatStrobe, input sector,
                   input statData, output protBits, output lockBit);
endinterface : splk_cmd_if

//--- hw/splk_pkg.sv
/*
 * shared constants for the sector protection lock block: opcodes, status
 * field positions, global protect decode values and frame widths.
 * assumes a 2 Mbit array split into 64 KB sectors and 24-bit addressing.
 */
package splk_pkg;
    localparam int NumSectors = 4;
    localparam int SectorIdxW = 2;
    localparam int SectorLsb = 16;         // 64 KB sectors
    localparam int AddrW = 24;
    localparam logic [7:0] OpReadProt = 8'h3c;
    localparam logic [7:0] OpProtect = 8'h36;
    localparam logic [7:0] OpUnprotect = 8'h39;
    localparam logic [7:0] OpWriteStatus = 8'h01;
    localparam int LockBitPos = 7;
    localparam int GlobalHi = 5;
    localparam int GlobalLo = 2;
    localparam logic [3:0] GlobalAllSet = 4'hf;
    localparam logic [3:0] GlobalAllClr = 4'h0;
    localparam logic [1:0] SumNone = 2'h0;
    localparam logic [1:0] SumSome = 2'h1;
    localparam logic [1:0] SumAll = 2'h3;
    localparam logic [5:0] CntOpEnd = 6'h07;
    localparam logic [5:0] CntAddrEnd = 6'h1f;
    localparam logic [5:0] CntDataEnd = 6'h0f;
    localparam logic [7:0] ByteProtected = 8'hff;
    localparam logic [7:0] ByteUnprotected = 8'h00;
    localparam logic [NumSectors-1:0] ProtResetAll = 4'hf;
    typedef enum logic [2:0] {
        SPLK_IDLE = 3'h0,
        SPLK_OPC = 3'h1,
        SPLK_ADDR = 3'h3,
        SPLK_DATA = 3'h2,
        SPLK_OUT = 3'h6,
        SPLK_SKIP = 3'h7
    } splk_state_t;
endpackage : splk_pkg

//--- hw/splk_prot_store.sv
/*
 * storage of per-sector protection bits and the protection lock bit, with
 * hardware/software locking.
 * assumes one-cycle command strobes from the frame engine and a synchronised pin.
 */
`timescale 1ns/1ps
module splk_prot_store (
    // clocking
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // pin level, active low write protect
    input wire logic wpLevel,
    // commands
    splk_cmd_if.store cmd,
    // status
    output logic hwLocked
);
    logic [splk_pkg::NumSectors-1:0] protReg;
    logic [splk_pkg::NumSectors-1:0] protNext;
    logic lockReg;
    logic lockNext;
    logic [3:0] globalCode;
    logic newLock;

    assign hwLocked = ~wpLevel & lockReg;
    assign globalCode = cmd.statData[splk_pkg::GlobalHi:splk_pkg::GlobalLo];
    assign newLock = cmd.statData[splk_pkg::LockBitPos];

    // lock bit and sector bits decided from the state before the write
    always_comb begin
        protNext = protReg;
        lockNext = lockReg;
        if (!hwLocked) begin
            if (!lockReg) begin
                // unlocked: per-sector and global operations allowed
                if (cmd.protStrobe) protNext[cmd.sector] = 1'b1;
                if (cmd.unprotStrobe) protNext[cmd.sector] = 1'b0;
                if (cmd.wrStatStrobe) begin
                    lockNext = newLock;
                    if (globalCode == splk_pkg::GlobalAllSet) protNext = '1;
                    if (globalCode == splk_pkg::GlobalAllClr) protNext = '0;
                end
            end else if (cmd.wrStatStrobe) begin
                // soft lock: only the lock bit moves, no global op
                lockNext = newLock;
            end
        end
    end

    // power-up: all sectors protected and unlocked
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            protReg <= splk_pkg::ProtResetAll;
            lockReg <= 1'b0;
        end else if (clkEn) begin
            protReg <= protNext;
            lockReg <= lockNext;
        end
    end

    assign cmd.protBits = protReg;
    assign cmd.lockBit = lockReg;
endmodule : splk_prot_store

//--- hw/splk_protect_lock.sv
/*
 * sector protection bits, protection lock bit and the serial frame engine that
 * reads one sector's protection byte back, plus protect/unprotect/status writes.
 * assumes spi pins are oversampled by sys_clk (mode 0), sampled on the rising
 * serial clock edge and shifted out after the falling edge.
 */
`timescale 1ns/1ps

// Function
// - after last address bit, drive every clock
// - repeat FFh if protected, 00h otherwise
// - chip select release ends read, tristates output
// - partial output byte accepted without error
// - read data ignores write-protect pin
// - protection depends only on sector bit
// - hardware lock needs pin low and lock bit
// - hardware lock discards protect, unprotect, status writes
// - clearing lock bit skips global operations
// - hardware locked bit cleared only by reset; here raising the pin also clears it
// - reset sets every protection bit, unlocked
// - pin high: lock bit settable, soft lock
// - locking write may also do global op
// - soft lock: lock clearable, protection frozen
// - lock bit zero: everything modifiable
// - summary field shows all, some, none
// - unlocked 7Fh write protects all sectors
// - unlocked 00h write unprotects all sectors
// - only bit 7 stored from status write
module splk_protect_lock (
    // clocking
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // serial pins
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEn,
    input wire logic writeProtN,
    // status
    output logic protectionLockBit,
    output logic [1:0] protectionSummaryField,
    output logic hwLocked,
    output logic [splk_pkg::NumSectors-1:0] sectorProtBits
);
    logic csSync;
    logic sckSync;
    logic siSync;
    logic wpSync;
    splk_cmd_if cmdBus ();

    splk_sync #(.ResetVal(1'b1)) uCsSync (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
        .asyncIn(chipSelN), .syncOut(csSync));
    splk_sync #(.ResetVal(1'b0)) uSckSync (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
        .asyncIn(serialClk), .syncOut(sckSync));
    splk_sync #(.ResetVal(1'b0)) uSiSync (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
        .asyncIn(serialIn), .syncOut(siSync));
    splk_sync #(.ResetVal(1'b1)) uWpSync (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
        .asyncIn(writeProtN), .syncOut(wpSync));

    splk_prot_store uStore (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
        .wpLevel(wpSync), .cmd(cmdBus.store), .hwLocked(hwLocked));

    // edge detection works on the synchronised copy only
    logic sckPrevReg;
    logic sckRise;
    logic sckFall;
    logic csActive;
    assign sckRise = sckSync & ~sckPrevReg;
    assign sckFall = ~sckSync & sckPrevReg;
    assign csActive = ~csSync;

    splk_pkg::splk_state_t stateReg;
    splk_pkg::splk_state_t stateNext;
    logic [5:0] cntReg;
    logic [5:0] cntNext;
    logic [7:0] opReg;
    logic [7:0] opNext;
    logic [splk_pkg::AddrW-1:0] addrReg;
    logic [splk_pkg::AddrW-1:0] addrNext;
    logic [7:0] dataReg;
    logic [7:0] dataNext;
    logic [2:0] outIdxReg;
    logic [2:0] outIdxNext;
    logic outBitReg;
    logic outBitNext;
    logic outEnReg;
    logic outEnNext;
    logic protNext;
    logic unprotNext;
    logic wrStatNext;
    logic protReg;
    logic unprotReg;
    logic wrStatReg;
    logic [splk_pkg::SectorIdxW-1:0] secReg;
    logic [splk_pkg::SectorIdxW-1:0] secNext;

    // sector index from the address just shifted in
    logic [splk_pkg::AddrW-1:0] addrShift;
    logic [splk_pkg::SectorIdxW-1:0] addrSector;
    logic [7:0] readByte;
    assign addrShift = {addrReg[splk_pkg::AddrW-2:0], siSync};
    assign addrSector = addrShift[splk_pkg::SectorLsb +: splk_pkg::SectorIdxW];
    // byte depends on the sector bit alone; the pin never enters
    assign readByte = cmdBus.protBits[secReg] ? splk_pkg::ByteProtected
                                              : splk_pkg::ByteUnprotected;

    // frame engine next state
    always_comb begin
        stateNext = stateReg;
        cntNext = cntReg;
        opNext = opReg;
        addrNext = addrReg;
        dataNext = dataReg;
        outIdxNext = outIdxReg;
        outBitNext = outBitReg;
        outEnNext = outEnReg;
        secNext = secReg;
        protNext = 1'b0;
        unprotNext = 1'b0;
        wrStatNext = 1'b0;
        if (!csActive) begin
            // a release at any bit position simply drops the frame
            stateNext = splk_pkg::SPLK_IDLE;
            outEnNext = 1'b0;
            cntNext = '0;
        end else begin
            unique case (stateReg)
                splk_pkg::SPLK_IDLE: begin
                    stateNext = splk_pkg::SPLK_OPC;
                    cntNext = '0;
                end
                splk_pkg::SPLK_OPC: begin
                    if (sckRise) begin
                        opNext = {opReg[6:0], siSync};
                        cntNext = cntReg + 6'h01;
                        if (cntReg == splk_pkg::CntOpEnd) begin
                            cntNext = '0;
                            unique case ({opReg[6:0], siSync})
                                splk_pkg::OpReadProt, splk_pkg::OpProtect,
                                splk_pkg::OpUnprotect: stateNext = splk_pkg::SPLK_ADDR;
                                splk_pkg::OpWriteStatus: stateNext = splk_pkg::SPLK_DATA;
                                default: stateNext = splk_pkg::SPLK_SKIP;
                            endcase
                        end
                    end
                end
                splk_pkg::SPLK_ADDR: begin
                    if (sckRise) begin
                        addrNext = addrShift;
                        cntNext = cntReg + 6'h01;
                        if (cntReg == splk_pkg::CntAddrEnd - 6'h08) begin
                            secNext = addrSector;
                            cntNext = '0;
                            if (opReg == splk_pkg::OpReadProt) begin
                                stateNext = splk_pkg::SPLK_OUT;
                                outIdxNext = 3'h7;
                            end else begin
                                protNext = (opReg == splk_pkg::OpProtect);
                                unprotNext = (opReg == splk_pkg::OpUnprotect);
                                stateNext = splk_pkg::SPLK_SKIP;
                            end
                        end
                    end
                end
                splk_pkg::SPLK_DATA: begin
                    if (sckRise) begin
                        dataNext = {dataReg[6:0], siSync};
                        cntNext = cntReg + 6'h01;
                        if (cntReg == splk_pkg::CntOpEnd) begin
                            wrStatNext = 1'b1;
                            stateNext = splk_pkg::SPLK_SKIP;
                        end
                    end
                end
                splk_pkg::SPLK_OUT: begin
                    // one bit per falling edge, byte repeats while selected
                    if (sckFall) begin
                        outEnNext = 1'b1;
                        outBitNext = readByte[outIdxReg];
                        outIdxNext = outIdxReg - 3'h1;
                    end
                end
                splk_pkg::SPLK_SKIP: begin
                    stateNext = splk_pkg::SPLK_SKIP;
                end
                default: stateNext = splk_pkg::SPLK_IDLE;
            endcase
        end
    end

    // frame registers; held while clock enable is low
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stateReg <= splk_pkg::SPLK_IDLE;
            cntReg <= '0;
            opReg <= '0;
            addrReg <= '0;
            dataReg <= '0;
            outIdxReg <= 3'h7;
            outBitReg <= 1'b0;
            outEnReg <= 1'b0;
            secReg <= '0;
            sckPrevReg <= 1'b0;
            protReg <= 1'b0;
            unprotReg <= 1'b0;
            wrStatReg <= 1'b0;
        end else if (clkEn) begin
            stateReg <= stateNext;
            cntReg <= cntNext;
            opReg <= opNext;
            addrReg <= addrNext;
            dataReg <= dataNext;
            outIdxReg <= outIdxNext;
            outBitReg <= outBitNext;
            outEnReg <= outEnNext;
            secReg <= secNext;
            sckPrevReg <= sckSync;
            protReg <= protNext;
            unprotReg <= unprotNext;
            wrStatReg <= wrStatNext;
        end
    end

    // command strobes to the store
    assign cmdBus.protStrobe = protReg;
    assign cmdBus.unprotStrobe = unprotReg;
    assign cmdBus.wrStatStrobe = wrStatReg;
    assign cmdBus.sector = secReg;
    assign cmdBus.statData = dataReg;

    // summary field from the live protection bits
    assign protectionSummaryField = (&cmdBus.protBits) ? splk_pkg::SumAll :
                                    (|cmdBus.protBits) ? splk_pkg::SumSome : splk_pkg::SumNone;
    // enable drops with the synchronised chip select, so the pin floats two sys_clk after select rises
    assign serialOutEn = outEnReg & csActive;
    assign serialOut = outBitReg;
    assign protectionLockBit = cmdBus.lockBit;
    assign sectorProtBits = cmdBus.protBits;
endmodule : splk_protect_lock

//--- hw/splk_sync.sv
/*
 * two flip-flop synchroniser for one pin level.
 * assumes the pin is asynchronous to sys_clk; first stage feeds only the second.
 */
`timescale 1ns/1ps
module splk_sync #(
    parameter logic ResetVal = 1'b0
) (
    // clocking
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // level
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1Reg;
    logic stage2Reg;

    // plain two-stage chain
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stage1Reg <= ResetVal;
            stage2Reg <= ResetVal;
        end else if (clkEn) begin
            stage1Reg <= asyncIn;
            stage2Reg <= stage1Reg;
        end
    end

    assign syncOut = stage2Reg;
endmodule : splk_sync
